// ### rtl/lsk_pkg.sv
`default_nettype none

package lsk_pkg;

    ////////////////////////////////////////////////////////////////////////
    // channel structure
    localparam int CHANNELS = 16; // sink channels per device
    localparam int GROUPS = 9; // switching groups
    localparam int CHAIN_WORDS = 1; // devices on the chain, one word each
    localparam int FIFO_DEPTH = 4; // frame buffer depth in words
    localparam logic [CHANNELS-1:0] ALL_OFF = 16'h0000; // latch image with every channel off
    localparam logic [CHANNELS-1:0] RESET_IMAGE = 16'h0000; // register and latch after reset

    ////////////////////////////////////////////////////////////////////////
    // timing, at the reference clock rate
    localparam int REF_CLK_MHZ = 125; // ref_clk rate
    localparam int GROUP_STEP_NS = 1; // delay from one group to the next
    localparam int GROUP_STEP_CYC_RAW = (GROUP_STEP_NS * REF_CLK_MHZ) / 1000; // rounded down
    localparam int GROUP_STEP_CYC = (GROUP_STEP_CYC_RAW < 1) ? 1 : GROUP_STEP_CYC_RAW; // at least one
    localparam int PRECHG_DELAY_NS = 16; // drive end to pull-up start
    localparam int PRECHG_DELAY_CYC = (PRECHG_DELAY_NS * REF_CLK_MHZ + 999) / 1000; // rounded up
    localparam int SCLK_HALF_NS = 32; // half period of the shift clock made by the host
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * REF_CLK_MHZ) / 1000; // rounded down

    ////////////////////////////////////////////////////////////////////////
    // counter widths
    localparam int STEP_W = 4; // group step divider width
    localparam int PRE_W = 4; // pre-charge delay counter width
    localparam int HALF_W = 4; // shift clock divider width
    localparam int BIT_W = 4; // bit index width
    localparam int WORD_W = 4; // word count width

endpackage

`default_nettype wire

// ### rtl/lsk_link_if.sv
`default_nettype none

interface lsk_link_if;
    logic shift_clk; // shift clock, made by the host
    logic serial_data_in; // serial data into the device
    logic transfer_strobe; // latch strobe, high = transparent
    logic force_off; // high = every channel off
    logic serial_chain_output; // serial data out of the device

    // the host end makes every link signal except the chain output
    modport host (
        output shift_clk,
        output serial_data_in,
        output transfer_strobe,
        output force_off,
        input serial_chain_output
    );

    // the device end samples the host's signals
    modport device (
        input shift_clk,
        input serial_data_in,
        input transfer_strobe,
        input force_off,
        output serial_chain_output
    );
endinterface

`default_nettype wire

// ### rtl/lsk_fifo.sv
`default_nettype none

module lsk_fifo #(
    parameter int WIDTH = 16, // word width
    parameter int DEPTH = 4 // words held
) (
    input wire logic ref_clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [WIDTH-1:0] in_data, // word to store
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic out_valid, // a word is held
    input wire logic out_ready // drain side takes the word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width

    logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage
    logic [AW-1:0] wr_ptr; // write index
    logic [AW-1:0] rd_ptr; // read index
    logic [AW:0] count; // words held
    logic push; // word written this cycle
    logic pop; // word read this cycle

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    ////////////////////////////////////////////////////////////////////////
    // storage write, no reset needed on data
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers and fill level
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### rtl/lsk_device.sv
// Overview of operation
// - sixteen channels, one data bit each
// - strobe high moves buffer to outputs
// - force-off high holds every channel off
// - force-off low: bit 1 sinks, 0 off
// - controller loads latch before enabling channels
// - controller keeps force-off high during power-up
// - groups switch one step after another
// - nine groups: 0, pairs k/16-k, 8
// - staggering on force-off and strobe changes
// - pull-up follows drive end after short delay
// - devices cascade through serial chain output
// - shift clock rise shifts input into lsb
// - latch transparent while strobe high, else holds
`default_nettype none

module lsk_device (
    input wire logic ref_clk, // system clock, 125 MHz
    input wire logic reset_n, // async reset, active low
    lsk_link_if.device link, // link from the host
    output logic [lsk_pkg::CHANNELS-1:0] channel_sink_n, // low = channel sinks current
    output logic [lsk_pkg::CHANNELS-1:0] precharge_on // high = pull-up switch closed
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, two stages each
    logic sclk_q1; // shift clock, first stage
    logic sclk_q2; // shift clock, second stage
    logic sclk_q3; // shift clock, edge history
    logic sdi_q1; // serial data, first stage
    logic sdi_q2; // serial data, second stage
    logic strobe_q1; // strobe, first stage
    logic strobe_q2; // strobe, second stage
    logic off_q1; // force-off, first stage
    logic off_q2; // force-off, second stage
    logic sclk_rise; // shift clock rising edge seen

    // pin inputs cross into ref_clk through two flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_q1 <= 1'b0;
            sclk_q2 <= 1'b0;
            sdi_q1 <= 1'b0;
            sdi_q2 <= 1'b0;
            strobe_q1 <= 1'b0;
            strobe_q2 <= 1'b0;
            off_q1 <= 1'b1; // safe side: channels held off
            off_q2 <= 1'b1;
        end
        else
        begin
            sclk_q1 <= link.shift_clk;
            sclk_q2 <= sclk_q1;
            sdi_q1 <= link.serial_data_in;
            sdi_q2 <= sdi_q1;
            strobe_q1 <= link.transfer_strobe;
            strobe_q2 <= strobe_q1;
            off_q1 <= link.force_off;
            off_q2 <= off_q1;
        end
    end

    // edge history for the shift clock, reads only the second stage
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_q3 <= 1'b0;
        end
        else
        begin
            sclk_q3 <= sclk_q2;
        end
    end

    assign sclk_rise = sclk_q2 & ~sclk_q3;

    ////////////////////////////////////////////////////////////////////////
    // shift register and output latch
    logic [lsk_pkg::CHANNELS-1:0] shift_reg; // serial buffer
    logic [lsk_pkg::CHANNELS-1:0] onoff_latch; // on/off data latch
    logic [lsk_pkg::CHANNELS-1:0] target; // wanted channel states

    // new bit enters the lsb on each shift clock rise
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_reg <= lsk_pkg::RESET_IMAGE;
        end
        else if (sclk_rise)
        begin
            shift_reg <= {shift_reg[lsk_pkg::CHANNELS-2:0], sdi_q2};
        end
    end

    // msb leaves toward the next device in the chain
    assign link.serial_chain_output = shift_reg[lsk_pkg::CHANNELS-1];

    // latch follows the register while the strobe is high
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            onoff_latch <= lsk_pkg::RESET_IMAGE;
        end
        else if (strobe_q2)
        begin
            onoff_latch <= shift_reg;
        end
    end

    // force-off overrides the latch, otherwise one bit per channel
    always_comb
    begin
        if (off_q2)
        begin
            target = lsk_pkg::ALL_OFF;
        end
        else
        begin
            target = onoff_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // group stagger
    logic [lsk_pkg::STEP_W-1:0] step_cnt; // group step divider
    logic step_tick; // one-cycle enable per group step
    logic [lsk_pkg::CHANNELS-1:0] stage [0:lsk_pkg::GROUPS-1]; // target delayed per group

    // divider makes the group step enable
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step_cnt <= '0;
        end
        else if (step_tick)
        begin
            step_cnt <= '0;
        end
        else
        begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    assign step_tick = (step_cnt == lsk_pkg::STEP_W'(lsk_pkg::GROUP_STEP_CYC - 1));

    // first group sees the target at once
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage[0] <= lsk_pkg::ALL_OFF;
        end
        else
        begin
            stage[0] <= target;
        end
    end

    // each later group sees it one step after the one before
    genvar gi;
    generate
        for (gi = 1; gi < lsk_pkg::GROUPS; gi++)
        begin : g_stage
            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage[gi] <= lsk_pkg::ALL_OFF;
                end
                else if (step_tick)
                begin
                    stage[gi] <= stage[gi-1];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // per-channel drive and pre-charge
    genvar ci;
    generate
        for (ci = 0; ci < lsk_pkg::CHANNELS; ci++)
        begin : g_chan
            // group of this channel: 0 alone, k with 16-k, 8 last
            localparam int GRP = (ci == 0) ? 0 : ((ci <= lsk_pkg::CHANNELS / 2) ? ci : lsk_pkg::CHANNELS - ci);
            logic next_on; // channel state from its group stage
            logic [lsk_pkg::PRE_W-1:0] off_cnt; // cycles since drive ended

            assign next_on = stage[GRP][ci];

            // sink output, active low
            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    channel_sink_n[ci] <= 1'b1;
                end
                else
                begin
                    channel_sink_n[ci] <= ~next_on;
                end
            end

            // pull-up closes a short delay after the drive ends
            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    off_cnt <= '0;
                    precharge_on[ci] <= 1'b0;
                end
                else if (next_on)
                begin
                    off_cnt <= '0; // drive active: restart delay
                    precharge_on[ci] <= 1'b0;
                end
                else if (off_cnt != lsk_pkg::PRE_W'(lsk_pkg::PRECHG_DELAY_CYC))
                begin
                    off_cnt <= off_cnt + 1'b1; // still waiting
                end
                else
                begin
                    precharge_on[ci] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ### rtl/lsk_host.sv
`default_nettype none

module lsk_host (
    input wire logic ref_clk, // system clock, 125 MHz
    input wire logic reset_n, // async reset, active low
    lsk_link_if.host link, // link to the device chain
    input wire logic [lsk_pkg::CHANNELS-1:0] frame_data, // on/off word, bit n = channel n
    input wire logic frame_valid, // word offered
    output logic frame_ready, // buffer has room
    input wire logic blank_req, // high = force every channel off
    output logic busy, // transfer in progress
    output logic loaded, // a frame has been latched since reset
    output logic chain_echo // synchronised chain output of the last device
);
    typedef enum logic [2:0] {LSK_IDLE, LSK_LOW, LSK_HIGH, LSK_STROBE, LSK_GAP} lsk_state_t;

    lsk_state_t state; // transfer state
    logic [lsk_pkg::CHANNELS-1:0] buf_data; // word from the buffer
    logic buf_valid; // buffer holds a word
    logic buf_take; // word taken from the buffer
    logic [lsk_pkg::CHANNELS-1:0] word; // word being shifted, msb first
    logic [lsk_pkg::BIT_W-1:0] bit_idx; // bits left in the word after the current one
    logic [lsk_pkg::WORD_W-1:0] word_cnt; // words shifted this frame
    logic [lsk_pkg::HALF_W-1:0] half_cnt; // shift clock divider
    logic half_tick; // one-cycle enable per half period
    logic echo_q1; // chain output, first stage

    ////////////////////////////////////////////////////////////////////////
    // frame buffer in the data path
    lsk_fifo #(
        .WIDTH(lsk_pkg::CHANNELS),
        .DEPTH(lsk_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_data(frame_data),
        .in_valid(frame_valid),
        .in_ready(frame_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(buf_take)
    );

    // words leave the buffer only between shifts
    assign buf_take = (state == LSK_IDLE) && buf_valid;
    assign busy = (state != LSK_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // half period divider for the shift clock
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            half_cnt <= '0;
        end
        else if (half_tick || state == LSK_IDLE)
        begin
            half_cnt <= '0;
        end
        else
        begin
            half_cnt <= half_cnt + 1'b1;
        end
    end

    assign half_tick = (half_cnt == lsk_pkg::HALF_W'(lsk_pkg::SCLK_HALF_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= LSK_IDLE;
            word <= '0;
            bit_idx <= '0;
            word_cnt <= '0;
        end
        else
        begin
            unique case (state)
                LSK_IDLE:
                begin
                    if (buf_take)
                    begin
                        word <= buf_data;
                        bit_idx <= lsk_pkg::BIT_W'(lsk_pkg::CHANNELS - 1);
                        state <= LSK_LOW;
                    end
                end
                LSK_LOW:
                begin
                    if (half_tick)
                    begin
                        state <= LSK_HIGH; // rising edge shifts the bit in
                    end
                end
                LSK_HIGH:
                begin
                    if (half_tick)
                    begin
                        word <= {word[lsk_pkg::CHANNELS-2:0], 1'b0};
                        if (bit_idx != '0)
                        begin
                            bit_idx <= bit_idx - 1'b1;
                            state <= LSK_LOW;
                        end
                        else if (word_cnt == lsk_pkg::WORD_W'(lsk_pkg::CHAIN_WORDS - 1))
                        begin
                            word_cnt <= '0;
                            state <= LSK_STROBE; // whole chain loaded
                        end
                        else
                        begin
                            word_cnt <= word_cnt + 1'b1;
                            state <= LSK_IDLE; // next device's word
                        end
                    end
                end
                LSK_STROBE:
                begin
                    if (half_tick)
                    begin
                        state <= LSK_GAP;
                    end
                end
                LSK_GAP:
                begin
                    if (half_tick)
                    begin
                        state <= LSK_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link outputs, all from flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.shift_clk <= 1'b0;
            link.serial_data_in <= 1'b0;
            link.transfer_strobe <= 1'b0;
        end
        else
        begin
            link.shift_clk <= (state == LSK_HIGH);
            link.serial_data_in <= word[lsk_pkg::CHANNELS-1];
            link.transfer_strobe <= (state == LSK_STROBE); // strobe only after loading
        end
    end

    // channels stay forced off until valid data is latched
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            loaded <= 1'b0;
            link.force_off <= 1'b1;
        end
        else
        begin
            if (state == LSK_GAP)
            begin
                loaded <= 1'b1;
            end
            link.force_off <= blank_req | ~loaded;
        end
    end

    // chain return crosses in through two flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            echo_q1 <= 1'b0;
            chain_echo <= 1'b0;
        end
        else
        begin
            echo_q1 <= link.serial_chain_output;
            chain_echo <= echo_q1;
        end
    end
endmodule

`default_nettype wire

// ### verification/lsk_link_properties.sv
`default_nettype none

module lsk_link_properties (
    input wire logic ref_clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic shift_clk, // link shift clock
    input wire logic transfer_strobe, // latch strobe
    input wire logic force_off, // all channels off
    input wire logic serial_chain_output, // chain data out
    input wire logic [15:0] channel_sink_n, // low = sinking
    input wire logic [15:0] precharge_on // high = pull-up on
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] blank_cnt; // cycles force-off held high
    logic [4:0] quiet_cnt; // cycles since strobe or force-off moved
    logic strobed; // a strobe seen since reset

    // saturating count of force-off high time
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            blank_cnt <= 5'h00;
        else if (!force_off)
            blank_cnt <= 5'h00;
        else if (blank_cnt != 5'h1f)
            blank_cnt <= blank_cnt + 5'h01;
    end

    // saturating count of cycles with no cause for output change
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            quiet_cnt <= 5'h00;
        else if (transfer_strobe || $changed(force_off))
            quiet_cnt <= 5'h00;
        else if (quiet_cnt != 5'h1f)
            quiet_cnt <= quiet_cnt + 5'h01;
    end

    // sticky strobe flag
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            strobed <= 1'b0;
        else if (transfer_strobe)
            strobed <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_prechg_off;
        (precharge_on & ~channel_sink_n) == 16'h0000;
    endproperty
    a_prechg_off: assert property (p_prechg_off) else $error("pull-up while sinking");

    property p_prechg_on;
        $rose(channel_sink_n[0]) |-> ##[1:4] (precharge_on[0] || !channel_sink_n[0]);
    endproperty
    a_prechg_on: assert property (p_prechg_on) else $error("pull-up late");

    property p_blank;
        blank_cnt >= 5'h0e |-> channel_sink_n == 16'hffff;
    endproperty
    a_blank: assert property (p_blank) else $error("channel on while blanked");

    property p_grp_first;
        $changed(channel_sink_n[0]) |-> $stable(channel_sink_n[15:1]);
    endproperty
    a_grp_first: assert property (p_grp_first) else $error("group one not alone");

    property p_grp_last;
        $changed(channel_sink_n[8]) |-> $stable(channel_sink_n[7:0]) && $stable(channel_sink_n[15:9]);
    endproperty
    a_grp_last: assert property (p_grp_last) else $error("last group not alone");

    property p_chain;
        $changed(serial_chain_output) |-> $past(shift_clk, 3) && !$past(shift_clk, 4);
    endproperty
    a_chain: assert property (p_chain) else $error("chain output moved off shift");

    property p_hold;
        quiet_cnt >= 5'h10 |-> $stable(channel_sink_n);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while latch holds");

    property p_strobe;
        $rose(transfer_strobe) |-> transfer_strobe[*4] ##1 !transfer_strobe && !shift_clk;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pulse wrong");

    property p_powerup;
        !strobed |-> force_off;
    endproperty
    a_powerup: assert property (p_powerup) else $error("unblanked before load");
endmodule

`default_nettype wire

// ### verification/lsk_tb.sv
`default_nettype none

module lsk_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0; // system clock
    logic reset_n = 1'b0; // async reset, active low
    logic [15:0] frame_data = 16'h0000; // word offered
    logic frame_valid = 1'b0; // offer strobe
    logic blank_req = 1'b0; // blank request
    logic frame_ready; // buffer room
    logic busy; // host busy
    logic loaded; // frame latched
    logic chain_echo; // synced chain output
    logic [15:0] channel_sink_n; // channel drive
    logic [15:0] precharge_on; // pull-up state
    int n_errors = 0; // mismatches
    int check_count = 0; // comparisons
    int seed = 17; // random seed
    logic [31:0] q[$]; // notes: word, expected image

    always #4 ref_clk = ~ref_clk; // 125 MHz

    ////////////////////////////////////////////////////////////////////////
    lsk_link_if lsk_link_if_inst ();
    lsk_host lsk_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(lsk_link_if_inst.host),
        .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .blank_req(blank_req), .busy(busy), .loaded(loaded), .chain_echo(chain_echo));
    lsk_device lsk_device_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(lsk_link_if_inst.device),
        .channel_sink_n(channel_sink_n), .precharge_on(precharge_on));
    lsk_link_properties lsk_link_properties_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .shift_clk(lsk_link_if_inst.shift_clk), .transfer_strobe(lsk_link_if_inst.transfer_strobe),
        .force_off(lsk_link_if_inst.force_off), .serial_chain_output(lsk_link_if_inst.serial_chain_output),
        .channel_sink_n(channel_sink_n), .precharge_on(precharge_on));

    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reset for 4 cycles, then check the idle state
    task automatic do_reset();
        @(negedge ref_clk);
        frame_valid = 1'b0;
        reset_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check(channel_sink_n, 16'hffff);
        check(precharge_on, 16'hffff);
        check({15'h0, lsk_link_if_inst.force_off}, 16'h0001);
        check({14'h0, busy, loaded}, 16'h0000);
    endtask

    // offer a word, hold until taken, note the expected image
    task automatic send(input logic [15:0] w, input logic [15:0] img);
        int n;
        @(negedge ref_clk);
        frame_data = w;
        frame_valid = 1'b1;
        n = 0;
        while (frame_ready !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400)
            n_errors++; // buffer never took the word
        @(posedge ref_clk);
        q.push_back({w, img});
    endtask

    // release the offer and wait for every noted frame
    task automatic wait_idle();
        int n;
        @(negedge ref_clk);
        frame_valid = 1'b0;
        n = 0;
        while ((q.size() != 0 || busy !== 1'b0) && n < 5000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 5000)
            n_errors++; // frames never finished
        repeat (24) @(negedge ref_clk);
        $display("test done at %0t", $time);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // result watcher: each finished frame against the oldest note
    initial
    begin
        logic [31:0] e;
        forever
        begin
            @(negedge busy);
            if (reset_n === 1'b1)
            begin
                @(negedge ref_clk);
                e = (q.size() > 0) ? q.pop_front() : 32'h0;
                check({15'h0, lsk_link_if_inst.serial_chain_output}, {15'h0, e[31]});
                check({15'h0, chain_echo}, {15'h0, e[31]});
                check({15'h0, loaded}, 16'h0001);
                repeat (20) @(negedge ref_clk);
                check(channel_sink_n, e[15:0]);
                check(precharge_on, e[15:0]);
            end
        end
    end

    // watchdog: about 2000 cycles of traffic expected, cut at 25000
    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end

    // main sequence
    initial
    begin
        logic [15:0] w;
        do_reset();
        // boundary words back to back until the buffer refuses
        send(16'h0001, 16'hfffe);
        send(16'h8000, 16'h7fff);
        send(16'hffff, 16'h0000);
        send(16'h0000, 16'hffff);
        send(16'ha5c3, 16'h5a3c);
        @(negedge ref_clk);
        frame_valid = 1'b0;
        check({15'h0, frame_ready}, 16'h0000);
        wait_idle();
        // random words
        repeat (6)
        begin
            w = 16'($random(seed));
            send(w, ~w);
        end
        wait_idle();
        // load while blanked, then unblank
        blank_req = 1'b1;
        repeat (20) @(negedge ref_clk);
        check(channel_sink_n, 16'hffff);
        send(16'h3c5a, 16'hffff);
        wait_idle();
        blank_req = 1'b0;
        repeat (20) @(negedge ref_clk);
        check(channel_sink_n, 16'hc3a5);
        $display("test done at %0t", $time);
        // reset in mid frame, then one clean frame
        send(16'h1234, 16'hedcb);
        @(negedge ref_clk);
        frame_valid = 1'b0;
        repeat (60) @(negedge ref_clk);
        q.delete();
        do_reset();
        send(16'h00ff, 16'hff00);
        wait_idle();
        summarize();
    end
endmodule

`default_nettype wire
